// [core/csm_params.svh]
// Offsets, field positions and reset values of the channel state and
// multi-channel modulation block. Included by the block and its bench.
`ifndef CSM_PARAMS_SVH
`define CSM_PARAMS_SVH

// Register indexes; the Wishbone byte address is four times the index.
`define CSM_IDX_STATE     16'he8a8
`define CSM_IDX_MODIFY    16'he8aa
`define CSM_IDX_MOD_CTRL  16'he8c0
`define CSM_IDX_PAT_SHD   16'he89e
`define CSM_IDX_PAT_ACT   16'he89a
`define CSM_IDX_MCM_CTRL  16'he8bc
`define CSM_IDX_PASSIVE   16'he8c4

// Channel state register fields.
`define CSM_ST_INV_BIT    15
`define CSM_ST_PS_LSB     8
`define CSM_ST_CH3_BIT    6
`define CSM_ST_HALL_LSB   3

// Modify register fields: clear strobes high byte, set strobes low byte.
`define CSM_MOD_CLR_LSB   8
`define CSM_MOD_CH3_CLR   14
`define CSM_MOD_CH3_SET   6

// Modulation control fields.
`define CSM_MC_T12EN_LSB  0
`define CSM_MC_MULTI_BIT  7
`define CSM_MC_T13EN_LSB  8

// Pattern registers and multi-channel control fields.
`define CSM_PAT_REQ_BIT   7
`define CSM_PAT_RFLG_BIT  6
`define CSM_MCM_SEL_LSB   0
`define CSM_MCM_SYN_LSB   4

`define CSM_RESET_VALUE   16'h0000

`endif

// [core/csm_pkg.sv]
// Types shared by the channel state and multi-channel modulation block.
// Field positions and offsets live in csm_params.svh.
package csm_pkg;

  // Trigger event select codes; 11x is reserved.
  typedef enum logic [2:0] {
    CSM_SEL_NONE   = 3'h0,
    CSM_SEL_HALL   = 3'h1,
    CSM_SEL_SEC_PM = 3'h2,
    CSM_SEL_ONE_DN = 3'h3,
    CSM_SEL_CH1_UP = 3'h4,
    CSM_SEL_PER_UP = 3'h5
  } csm_sel_t;

  // Synchronisation select codes; 11 is reserved.
  typedef enum logic [1:0] {
    CSM_SYN_DIRECT = 2'h0,
    CSM_SYN_SEC_ZM = 2'h1,
    CSM_SYN_FST_ZU = 2'h2
  } csm_syn_t;

endpackage

// [core/csm_channel_state.sv]
// Channel state bits, passive-state logic and multi-channel pattern
// modulation of a seven-output capture/compare unit, with a Wishbone slave.
// Assumes timer events arrive as one-cycle pulses on mclk_in and that the
// Hall pins are asynchronous.
//
// Register access over Wishbone was decided locally.
`timescale 1ns/1ns
`include "csm_params.svh"

module csm_channel_state #(
  parameter int ADR_W = 18
) (
  // Clock and reset
  input  wire logic              mclk_in,
  input  wire logic              rstn_in,
  // Wishbone slave
  input  wire logic              wb_cyc_in,
  input  wire logic              wb_stb_in,
  input  wire logic              wb_we_in,
  input  wire logic [ADR_W-1:0]  wb_adr_in,
  input  wire logic [3:0]        wb_sel_in,
  input  wire logic [31:0]       wb_dat_in,
  output logic      [31:0]       wb_dat_out,
  output logic                   wb_ack_out,
  // Timer switching rules, channels 0..3, and capture mode of channels 0..2
  input  wire logic [3:0]        hw_state_set_in,
  input  wire logic [3:0]        hw_state_clr_in,
  input  wire logic [2:0]        capture_mode_in,
  input  wire logic              timer12_shadow_in,
  input  wire logic              timer13_shadow_in,
  input  wire logic              second_timer_compare_signal_in,
  // Hall pins and their sampling strobe
  input  wire logic [2:0]        hall_pins_in,
  input  wire logic              hall_sample_in,
  // Trigger and synchronisation events
  input  wire logic              correct_hall_event_in,
  input  wire logic              timer13_period_match_in,
  input  wire logic              timer12_one_match_in,
  input  wire logic              channel1_upcount_compare_in,
  input  wire logic              timer12_period_match_in,
  input  wire logic              timer13_zero_match_in,
  input  wire logic              timer12_zero_up_in,
  // Gate outputs: CC60, COUT60, CC61, COUT61, CC62, COUT62, then COUT63
  output logic      [5:0]        gate_out,
  output logic                   cout63_out
);

  // The register map needs byte address bits up to 17.
  if (ADR_W < 18) begin : g_adr_check
    $error("ADR_W must reach the highest register byte address");
  end

  logic [15:0] ch_state_reg;
  logic        inv_reg;
  logic [6:0]  ps_shadow_reg;
  logic [6:0]  ps_active_reg;
  logic [6:0]  passive_level_reg;
  logic [15:0] mod_ctrl_reg;
  logic [5:0]  pat_shadow_reg;
  logic [5:0]  pat_active_reg;
  logic        remind_reg;
  logic [2:0]  sel_reg;
  logic [1:0]  syn_reg;
  logic [3:0]  st_reg;
  logic [2:0]  hall_meta_reg;
  logic [2:0]  hall_sync_reg;
  logic [2:0]  hall_reg;
  logic        ack_reg;

  logic [15:0] wmask;
  logic [15:0] wdata;
  logic [15:0] widx;
  logic        wr;
  logic        sw_req;
  logic        trig_evt;
  logic        sync_evt;
  logic        direct;
  logic        xfer;

  assign widx  = wb_adr_in[17:2];
  assign wmask = {{8{wb_sel_in[1]}}, {8{wb_sel_in[0]}}};
  assign wdata = wb_dat_in[15:0] & wmask;
  assign wr    = wb_cyc_in & wb_stb_in & wb_we_in & ack_reg;

  // Bus handshake: one wait cycle, ack for one cycle, every address answered.
  always_ff @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= wb_cyc_in & wb_stb_in & ~ack_reg;
    end
  end
  assign wb_ack_out = ack_reg;

  assign ch_state_reg = {inv_reg, ps_active_reg, 1'b0, st_reg[3], hall_reg, st_reg[2:0]};

  // Read data is latched when the request arrives; unmapped and write-only read 0.
  always_ff @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      wb_dat_out <= 32'h0000_0000;
    end else if (wb_cyc_in && wb_stb_in && !ack_reg) begin
      case (widx)
        `CSM_IDX_STATE:    wb_dat_out <= {16'h0000, ch_state_reg};
        `CSM_IDX_MOD_CTRL: wb_dat_out <= {16'h0000, mod_ctrl_reg};
        `CSM_IDX_PAT_SHD:  wb_dat_out <= {26'h0000000, pat_shadow_reg};
        `CSM_IDX_PAT_ACT:  wb_dat_out <= {25'h0000000, remind_reg, pat_active_reg};
        `CSM_IDX_MCM_CTRL: wb_dat_out <= {26'h0000000, syn_reg, 1'b0, sel_reg};
        `CSM_IDX_PASSIVE:  wb_dat_out <= {25'h0000000, passive_level_reg};
        default:           wb_dat_out <= 32'h0000_0000;
      endcase
    end
  end

  // Hall pins: two-stage synchroniser, then held at each sampling strobe.
  always_ff @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      hall_meta_reg <= 3'h0;
      hall_sync_reg <= 3'h0;
      hall_reg      <= 3'h0;
    end else begin
      hall_meta_reg <= hall_pins_in;
      hall_sync_reg <= hall_meta_reg;
      if (hall_sample_in) begin
        hall_reg <= hall_sync_reg;
      end
    end
  end

  // State bits: timer switching first, then the software strobes on top.
  genvar c;
  generate
    for (c = 0; c < 4; c++) begin : g_state
      localparam int SET_B = (c == 3) ? `CSM_MOD_CH3_SET : c;
      localparam int CLR_B = (c == 3) ? `CSM_MOD_CH3_CLR : c + `CSM_MOD_CLR_LSB;
      logic hw_v;
      logic s_w;
      logic r_w;
      assign s_w  = wr && (widx == `CSM_IDX_MODIFY) && wdata[SET_B];
      assign r_w  = wr && (widx == `CSM_IDX_MODIFY) && wdata[CLR_B];
      // Compare or capture outcome as decided by the timer logic.
      assign hw_v = hw_state_set_in[c] ? 1'b1 :
                    (hw_state_clr_in[c] ? 1'b0 : st_reg[c]);
      always_ff @(posedge mclk_in or negedge rstn_in) begin
        if (!rstn_in) begin
          st_reg[c] <= 1'b0;
        end else if (s_w && r_w) begin
          st_reg[c] <= ~hw_v;
        end else if (s_w) begin
          st_reg[c] <= 1'b1;
        end else if (r_w) begin
          st_reg[c] <= 1'b0;
        end else begin
          st_reg[c] <= hw_v;
        end
      end
    end
  endgenerate

  // Software registers.
  always_ff @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      inv_reg           <= 1'b0;
      ps_shadow_reg     <= 7'h00;
      mod_ctrl_reg      <= `CSM_RESET_VALUE;
      pat_shadow_reg    <= 6'h00;
      sel_reg           <= 3'h0;
      syn_reg           <= 2'h0;
      passive_level_reg <= 7'h00;
    end else if (wr) begin
      case (widx)
        `CSM_IDX_STATE: begin
          if (wb_sel_in[1]) begin
            inv_reg       <= wb_dat_in[`CSM_ST_INV_BIT];
            ps_shadow_reg <= wb_dat_in[`CSM_ST_INV_BIT-1:`CSM_ST_PS_LSB];
          end
        end
        `CSM_IDX_MOD_CTRL: mod_ctrl_reg <= (mod_ctrl_reg & ~wmask) | wdata;
        `CSM_IDX_PAT_SHD: begin
          if (wb_sel_in[0]) begin
            pat_shadow_reg <= wb_dat_in[5:0];
          end
        end
        `CSM_IDX_MCM_CTRL: begin
          if (wb_sel_in[0]) begin
            sel_reg <= wb_dat_in[`CSM_MCM_SEL_LSB+2:`CSM_MCM_SEL_LSB];
            syn_reg <= wb_dat_in[`CSM_MCM_SYN_LSB+1:`CSM_MCM_SYN_LSB];
          end
        end
        `CSM_IDX_PASSIVE: begin
          if (wb_sel_in[0]) begin
            passive_level_reg <= wb_dat_in[6:0];
          end
        end
        default: begin
        end
      endcase
    end
  end

  // Passive selects of channels 0..2 follow the first timer, channel 3 the second.
  always_ff @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      ps_active_reg <= 7'h00;
    end else begin
      if (timer12_shadow_in) begin
        ps_active_reg[5:0] <= ps_shadow_reg[5:0];
      end
      if (timer13_shadow_in) begin
        ps_active_reg[6] <= ps_shadow_reg[6];
      end
    end
  end

  // Trigger and synchronisation decode.
  always_comb begin
    case (csm_pkg::csm_sel_t'(sel_reg))
      csm_pkg::CSM_SEL_NONE:   trig_evt = 1'b0;
      csm_pkg::CSM_SEL_HALL:   trig_evt = correct_hall_event_in;
      csm_pkg::CSM_SEL_SEC_PM: trig_evt = timer13_period_match_in;
      csm_pkg::CSM_SEL_ONE_DN: trig_evt = timer12_one_match_in;
      csm_pkg::CSM_SEL_CH1_UP: trig_evt = channel1_upcount_compare_in;
      csm_pkg::CSM_SEL_PER_UP: trig_evt = timer12_period_match_in;
      default:                 trig_evt = 1'b0;
    endcase
  end

  always_comb begin
    direct = 1'b0;
    case (csm_pkg::csm_syn_t'(syn_reg))
      csm_pkg::CSM_SYN_DIRECT: begin
        sync_evt = 1'b0;
        direct   = 1'b1;
      end
      csm_pkg::CSM_SYN_SEC_ZM: sync_evt = timer13_zero_match_in;
      csm_pkg::CSM_SYN_FST_ZU: sync_evt = timer12_zero_up_in;
      default:                 sync_evt = 1'b0;
    endcase
  end

  assign sw_req = wr && (widx == `CSM_IDX_PAT_SHD) && wdata[`CSM_PAT_REQ_BIT];
  assign xfer   = sw_req || (direct && trig_evt) || (remind_reg && sync_evt);

  // A software request moves the value being written in the same access.
  always_ff @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      pat_active_reg <= 6'h00;
      remind_reg     <= 1'b0;
    end else begin
      if (sw_req) begin
        pat_active_reg <= wb_dat_in[5:0];
      end else if (xfer) begin
        pat_active_reg <= pat_shadow_reg;
      end
      // A trigger outside direct mode sets the flag even if a transfer happens now; reserved sync does nothing.
      if (trig_evt && !direct && syn_reg != 2'h3) begin
        remind_reg <= 1'b1;
      end else if (xfer) begin
        remind_reg <= 1'b0;
      end
    end
  end

  // Output modulation.
  logic       sec_mod;
  logic [5:0] out_active;
  assign sec_mod = second_timer_compare_signal_in ^ inv_reg;

  generate
    for (c = 0; c < 6; c++) begin : g_out
      logic ch_act;
      logic ps_eff;
      logic fst_en;
      logic sec_en;
      assign ps_eff = capture_mode_in[c/2] ? 1'b0 : ps_active_reg[c];
      assign ch_act = st_reg[c/2] ^ ps_eff;
      assign fst_en = mod_ctrl_reg[`CSM_MC_T12EN_LSB+c];
      assign sec_en = mod_ctrl_reg[`CSM_MC_T13EN_LSB+c];
      assign out_active[c] = (fst_en || sec_en) && (!fst_en || ch_act) &&
                             (!sec_en || sec_mod) &&
                             (!mod_ctrl_reg[`CSM_MC_MULTI_BIT] || pat_active_reg[c]);
    end
  endgenerate

  always_ff @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      gate_out   <= 6'h00;
      cout63_out <= 1'b0;
    end else begin
      gate_out   <= passive_level_reg[5:0] ^ out_active;
      cout63_out <= passive_level_reg[6] ^ (st_reg[3] ^ ps_active_reg[6]);
    end
  end

  // Checks.
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!rstn_in);

  a_ack_single_pulse: assert property (wb_ack_out |=> !wb_ack_out)
    else $error("ack held for more than one cycle");
  a_clear_strobe: assert property (
    wr && widx == `CSM_IDX_MODIFY && wdata[8] && !wdata[0] |=> !st_reg[0])
    else $error("clear strobe did not clear channel 0");
  a_set_strobe: assert property (
    wr && widx == `CSM_IDX_MODIFY && wdata[6] && !wdata[14] |=> st_reg[3])
    else $error("set strobe did not set channel 3");
  a_toggle_both: assert property (
    wr && widx == `CSM_IDX_MODIFY && wdata[1] && wdata[9] && !hw_state_set_in[1]
    && !hw_state_clr_in[1] |=> st_reg[1] != $past(st_reg[1]))
    else $error("set and clear together did not toggle");
  a_hw_switch: assert property (!wr && hw_state_set_in[2] |=> st_reg[2])
    else $error("switching rule did not set channel 2");
  a_hw_clear: assert property (
    !wr && hw_state_clr_in[0] && !hw_state_set_in[0] |=> !st_reg[0])
    else $error("switching rule did not clear channel 0");
  a_hall_sample: assert property (
    hall_sample_in |=> ch_state_reg[5:3] == $past(hall_sync_reg))
    else $error("sampled hall bits not shown");
  a_ps_shadow: assert property (
    !timer12_shadow_in ##1 !timer12_shadow_in |-> $stable(ps_active_reg[5:0]))
    else $error("passive selects changed without a shadow transfer");
  a_pattern_hold: assert property (!xfer |=> $stable(pat_active_reg))
    else $error("pattern changed without a transfer");
  a_sw_request: assert property (
    sw_req |=> pat_active_reg == $past(wb_dat_in[5:0]))
    else $error("software request did not load the written pattern");
  a_reserved_keep: assert property (
    sel_reg[2:1] == 2'h3 && !sw_req && !(remind_reg && sync_evt)
    |=> $stable(pat_active_reg) && (remind_reg || !$past(remind_reg) || $past(xfer)))
    else $error("reserved trigger code changed pattern");
  a_reserved_sync: assert property (
    syn_reg == 2'h3 && !sw_req |=> $stable(pat_active_reg) && $stable(remind_reg))
    else $error("reserved sync code changed pattern or flag");
  a_direct_xfer: assert property (
    direct && trig_evt && !sw_req |=> pat_active_reg == $past(pat_shadow_reg) && !remind_reg)
    else $error("direct mode did not transfer at the trigger");
  a_remind_set: assert property (
    trig_evt && !direct && syn_reg != 2'h3 |=> remind_reg)
    else $error("reminder flag not set by trigger");
  a_remind_clear: assert property (
    xfer && !(trig_evt && !direct && syn_reg != 2'h3) |=> !remind_reg)
    else $error("reminder flag not cleared by transfer");
  a_mcm_block: assert property (
    mod_ctrl_reg[`CSM_MC_MULTI_BIT] && !pat_active_reg[0] ##1 $stable(passive_level_reg[0])
    |-> gate_out[0] == passive_level_reg[0])
    else $error("masked output left its passive level");
  // Gate checks look one cycle back, as gate_out is registered.
  a_passive_level: assert property (
    !mod_ctrl_reg[0] && !mod_ctrl_reg[8] |=> gate_out[0] == $past(passive_level_reg[0]))
    else $error("unmodulated output left its passive level");
  a_capture_ignore: assert property (
    capture_mode_in[0] && mod_ctrl_reg[0] && !mod_ctrl_reg[8] && !mod_ctrl_reg[7]
    |=> gate_out[0] == $past(passive_level_reg[0] ^ st_reg[0]))
    else $error("capture channel used its passive select");
  a_inv_mod: assert property (
    !mod_ctrl_reg[0] && mod_ctrl_reg[8] && !mod_ctrl_reg[7]
    |=> gate_out[0] == $past(passive_level_reg[0] ^ second_timer_compare_signal_in ^ inv_reg))
    else $error("second timer modulation not inverted as selected");

endmodule // csm_channel_state

// [verification/csm_far_side.sv]
// Behavioural far side: three Hall sensors and the gate drivers they feed.
// Assumes the bench names the Hall pattern and reads back the latched gate levels.
`timescale 1ns/1ns

module csm_far_side (
  // Clock
  input  wire logic       mclk_in,
  // Gate drive from the block
  input  wire logic [5:0] gate_in,
  input  wire logic       cout63_in,
  // Hall pattern asked for by the bench
  input  wire logic [2:0] hall_req_in,
  // Sensor pins and the levels latched by the drivers
  output logic      [2:0] hall_pins_out,
  output logic      [6:0] drive_out
);
  always_ff @(posedge mclk_in) begin
    hall_pins_out <= hall_req_in;
    drive_out     <= {cout63_in, gate_in};
  end
endmodule // csm_far_side

// [verification/testbench.sv]
// Self-checking bench for the channel state and multi-channel modulation block.
// Assumes csm_channel_state with csm_params.svh and the far-side model csm_far_side.
`timescale 1ns/1ns
`include "csm_params.svh"

module testbench;
  logic        mclk_in, rstn_in, cyc, stb, we, ack, hsmp, sh12, sh13, t13sig, c63;
  logic [17:0] adr;
  logic [3:0]  sel, hset, hclr;
  logic [31:0] wdat, rdat;
  logic [2:0]  cap, hall_req, hall_pins, hall_m;
  logic [4:0]  ev, e;
  logic [1:0]  sy, y;
  logic [5:0]  gate, pat_m;
  logic [6:0]  st_m, ps_m, ps_shd, pl_m, drive;
  logic [15:0] mc_m, q, d;
  logic        inv_m, rem_m;
  integer      seed;
  int          bad_count, n_checks;

  csm_channel_state dut (.mclk_in(mclk_in), .rstn_in(rstn_in), .wb_cyc_in(cyc),
    .wb_stb_in(stb), .wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(sel), .wb_dat_in(wdat),
    .wb_dat_out(rdat), .wb_ack_out(ack), .hw_state_set_in(hset), .hw_state_clr_in(hclr),
    .capture_mode_in(cap), .timer12_shadow_in(sh12), .timer13_shadow_in(sh13),
    .second_timer_compare_signal_in(t13sig), .hall_pins_in(hall_pins),
    .hall_sample_in(hsmp), .correct_hall_event_in(ev[0]), .timer13_period_match_in(ev[1]),
    .timer12_one_match_in(ev[2]), .channel1_upcount_compare_in(ev[3]),
    .timer12_period_match_in(ev[4]), .timer13_zero_match_in(sy[0]),
    .timer12_zero_up_in(sy[1]), .gate_out(gate), .cout63_out(c63));

  csm_far_side far (.mclk_in(mclk_in), .gate_in(gate), .cout63_in(c63),
    .hall_req_in(hall_req), .hall_pins_out(hall_pins), .drive_out(drive));

  initial begin
    mclk_in = 1'b0;
    forever #4 mclk_in = ~mclk_in;
  end

  task automatic end_sim();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // Classic single cycle; the request stands until ack is sampled high.
  task automatic wb(input logic w, input logic [15:0] idx, input logic [15:0] dv);
    int n;
    @(posedge mclk_in);
    cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= {idx, 2'b00}; sel <= 4'h3;
    wdat <= {16'h0000, dv};
    n = 0;
    do begin
      @(posedge mclk_in);
      n++;
    end while (ack !== 1'b1 && n < 40);
    if (n >= 40) begin
      bad_count++;
      end_sim();
    end
    q = rdat[15:0];
    cyc <= 1'b0; stb <= 1'b0;
  endtask

  task automatic pulse(input logic [4:0] ee, input logic [1:0] ss);
    @(posedge mclk_in);
    ev <= ee; sy <= ss;
    @(posedge mclk_in);
    ev <= 5'h00; sy <= 2'h0;
    repeat (2) @(posedge mclk_in);
  endtask

  task automatic shadow(input logic a, input logic b);
    @(posedge mclk_in);
    sh12 <= a; sh13 <= b;
    @(posedge mclk_in);
    sh12 <= 1'b0; sh13 <= 1'b0;
    repeat (2) @(posedge mclk_in);
    if (a) ps_m[5:0] = ps_shd[5:0];
    if (b) ps_m[6] = ps_shd[6];
  endtask

  function automatic logic [6:0] upd(input logic [6:0] s0, input logic [15:0] m);
    logic [6:0] s, c;
    s = m[6:0] & 7'h47;
    c = m[14:8] & 7'h47;
    return ((s0 & ~(c & ~s)) | (s & ~c)) ^ (s & c);
  endfunction

  function automatic logic [15:0] exp_st();
    return {inv_m, ps_m, 1'b0, st_m[6], hall_m, st_m[2:0]};
  endfunction

  function automatic logic [6:0] exp_gate();
    logic [6:0] g;
    logic       a;
    int         ch;
    for (int k = 0; k < 6; k++) begin
      ch = k / 2;
      a = (mc_m[k] | mc_m[k+8]) & (!mc_m[k] | (st_m[ch] ^ (ps_m[k] & !cap[ch])))
        & (!mc_m[k+8] | (t13sig ^ inv_m)) & (!mc_m[7] | pat_m[k]);
      g[k] = pl_m[k] ^ a;
    end
    g[6] = pl_m[6] ^ st_m[6] ^ ps_m[6];
    return g;
  endfunction

  initial begin
    #400000;
    bad_count++;
    end_sim();
  end

  initial begin
    {cyc, stb, we, hsmp, sh12, sh13, t13sig, ev, sy, cap, hall_req, hset, hclr} = '0;
    adr = '0; sel = '0; wdat = '0;
    {st_m, ps_m, ps_shd, pl_m, mc_m, pat_m, inv_m, rem_m, hall_m} = '0;
    seed = 32'hff2d; bad_count = 0; n_checks = 0; rstn_in = 1'b0;
    repeat (12) @(posedge mclk_in);
    rstn_in <= 1'b1;
    wb(0, `CSM_IDX_STATE, 16'h0000);
    check(q, 16'h0000);
    wb(0, `CSM_IDX_MODIFY, 16'h0000);
    check(q, 16'h0000);
    wb(0, 16'h0001, 16'h0000);
    check(q, 16'h0000);
    for (int i = 0; i < 24; i++) begin
      d = (i == 0) ? 16'h4747 : (i == 1) ? 16'h0047 : (i == 2) ? 16'h4700 : 16'($random(seed));
      wb(1, `CSM_IDX_MODIFY, d);
      st_m = upd(st_m, d);
      wb(0, `CSM_IDX_STATE, 16'h0000);
      check(q, exp_st());
    end
    for (int i = 0; i < 6; i++) begin
      d = 16'($random(seed));
      @(posedge mclk_in);
      hall_req <= d[10:8]; hset <= d[3:0]; hclr <= d[7:4];
      @(posedge mclk_in);
      hset <= 4'h0; hclr <= 4'h0;
      for (int c = 0; c < 4; c++) if (d[c] | d[c+4]) st_m[c == 3 ? 6 : c] = d[c];
      repeat (4) @(posedge mclk_in);
      hsmp <= 1'b1;
      @(posedge mclk_in);
      hsmp <= 1'b0;
      hall_m = d[10:8];
      wb(0, `CSM_IDX_STATE, 16'h0000);
      check(q, exp_st());
      d = 16'($random(seed));
      wb(1, `CSM_IDX_STATE, d);
      inv_m = d[15]; ps_shd = d[14:8];
      wb(0, `CSM_IDX_STATE, 16'h0000);
      check(q, exp_st());
      shadow(i[0], !i[0]);
      wb(0, `CSM_IDX_STATE, 16'h0000);
      check(q, exp_st());
    end
    for (int m = 0; m < 32; m++) begin
      wb(1, `CSM_IDX_MCM_CTRL, {10'h000, m[4:3], 1'b0, m[2:0]});
      d = 16'($random(seed));
      wb(1, `CSM_IDX_PAT_SHD, d | 16'h0080);
      pat_m = d[5:0]; rem_m = 1'b0; d = ~d;
      wb(0, `CSM_IDX_PAT_ACT, 16'h0000);
      check(q, {9'h000, rem_m, pat_m});
      wb(1, `CSM_IDX_PAT_SHD, d & 16'h003f);
      e = (m[2:0] >= 1 && m[2:0] <= 5) ? 5'(1 << (m[2:0] - 1)) : 5'h00;
      y = (m[4:3] == 1) ? 2'h1 : (m[4:3] == 2) ? 2'h2 : 2'h0;
      pulse(~e, 2'h0);
      wb(0, `CSM_IDX_PAT_ACT, 16'h0000);
      check(q, {9'h000, rem_m, pat_m});
      pulse(e, 2'h0);
      if (e != 0 && m[4:3] == 0) pat_m = d[5:0];
      if (e != 0 && m[4:3] != 0 && m[4:3] != 3) rem_m = 1'b1;
      wb(0, `CSM_IDX_PAT_ACT, 16'h0000);
      check(q, {9'h000, rem_m, pat_m});
      pulse(5'h00, ~y);
      wb(0, `CSM_IDX_PAT_ACT, 16'h0000);
      check(q, {9'h000, rem_m, pat_m});
      pulse(5'h00, y);
      if (rem_m && y != 0) begin
        pat_m = d[5:0];
        rem_m = 1'b0;
      end
      wb(0, `CSM_IDX_PAT_ACT, 16'h0000);
      check(q, {9'h000, rem_m, pat_m});
    end
    for (int i = 0; i < 40; i++) begin
      d = 16'($random(seed));
      wb(1, `CSM_IDX_MODIFY, d);
      st_m = upd(st_m, d);
      d = 16'($random(seed));
      wb(1, `CSM_IDX_STATE, d);
      inv_m = d[15]; ps_shd = d[14:8];
      shadow(1'b1, 1'b1);
      d = 16'($random(seed));
      wb(1, `CSM_IDX_PASSIVE, d);
      pl_m = d[6:0];
      d = 16'($random(seed)) & 16'h3fbf;
      wb(1, `CSM_IDX_MOD_CTRL, d);
      mc_m = d;
      wb(0, `CSM_IDX_MOD_CTRL, 16'h0000);
      check(q, mc_m);
      d = 16'($random(seed));
      wb(1, `CSM_IDX_PAT_SHD, d | 16'h0080);
      pat_m = d[5:0];
      @(posedge mclk_in);
      cap <= d[10:8]; t13sig <= d[11];
      repeat (4) @(posedge mclk_in);
      check({9'h000, drive}, {9'h000, exp_gate()});
    end
    end_sim();
  end
endmodule // testbench
